// ---- rtl/imt_timer.sv ----
// two-channel 16-bit interval match timer with register port and interrupts
// assumes one clock core_clk, synchronous reset rstn, a one-cycle strobe bus
// Contract
// R1: two independent channels, each with its own 16-bit counter raising interrupts.
// R2: two-bit clock select per channel picks clock divided by 8, 32, 128, 512.
// R3: run register bit 1 runs channel 1, bit 0 runs channel 0.
// R4: run register bits 15..2 read zero; software writes zero there.
// R5: run register clears on reset and on standby entry.
// R6: control/status bit 7 is match flag, set once counter equalled constant.
// R7: software clears flag only by writing 0; writing 1 has no effect.
// R8: bit 6 enables match interrupt request while the flag is set.
// R9: control/status bits 15..8 and 5..2 read zero; write zero.
// R10: control/status clears on reset and on standby entry.
// R11: counter increments on selected clock while running, holds while stopped.
// R12: on counter equal to constant, counter clears, flag sets, counting resumes.
// R13: counter clears on reset and on standby entry.
// R14: compare constant sets interval, resets to all ones.
// R15: match acts at the next count clock after equality, counter going zero.
// R16: match clear beats a coincident software write to the counter.
// R17: counter write beats coincident increment; unwritten byte keeps value.
// R18: software clears flag by reading it as 1, then writing 0; the code clears it on any write of 0 to bit 7, read or not.
// R19: prescaler makes single-cycle count enables; counter advances only on them.
//
// The placing of the registers and the strobed register port were chosen for this implementation.

module imt_timer (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic standby,
  input wire imt_pkg::imt_bus_req_t bus_req,
  output logic [15:0] rdata,
  output logic irq,
  output logic [1:0] match_irq
);

  // ==========================================
  // state
  imt_pkg::imt_state_t st_q;
  imt_pkg::imt_state_t st_d;

  logic [1:0] tick;
  logic [1:0] match;
  logic [1:0] wr_csr;
  logic [1:0] wr_cnt;
  logic [1:0] wr_cor;
  logic [1:0] rd_hit;

  // ==========================================
  // per-channel prescale tap and match detect
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [`IMT_PRE_W-1:0] mask;
    logic [3:0] nbits;
    localparam logic [7:0] CSR_A = 8'(`IMT_OFS_CSR0 + c * `IMT_CH_STRIDE);
    localparam logic [7:0] CNT_A = 8'(`IMT_OFS_CNT0 + c * `IMT_CH_STRIDE);
    localparam logic [7:0] COR_A = 8'(`IMT_OFS_COR0 + c * `IMT_CH_STRIDE);

    always_comb begin
      nbits = 4'(`IMT_DIV8_BITS + `IMT_DIV_STEP * st_q.ch[c].cks);
      mask = `IMT_PRE_W'((1 << nbits) - 1);
    end

    // one-cycle enable when the low bits of the prescaler wrap
    assign tick[c] = st_q.run[c] && ((st_q.pre & mask) == mask); // R2 R19
    assign match[c] = tick[c] && (st_q.ch[c].cnt == st_q.ch[c].cor); // R15
    assign wr_csr[c] = bus_req.wr && (bus_req.addr == CSR_A);
    assign wr_cnt[c] = bus_req.wr && (bus_req.addr == CNT_A);
    assign wr_cor[c] = bus_req.wr && (bus_req.addr == COR_A);
    assign rd_hit[c] = (bus_req.addr == CSR_A) || (bus_req.addr == CNT_A)
                       || (bus_req.addr == COR_A);
  end

  // ==========================================
  // byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [1:0] be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // ==========================================
  // next-state logic
  always_comb begin
    logic [15:0] csr_w;
    logic [1:0] ev;
    csr_w = 16'h0000;
    ev = 2'h0;
    st_d = st_q;
    st_d.pre = st_q.pre + `IMT_PRE_W'(1);

    // run register: only low bits exist
    if (bus_req.wr && bus_req.addr == `IMT_OFS_RUN && bus_req.be[0]) begin
      st_d.run = bus_req.wdata[1:0]; // R3 R4
    end

    for (int c = 0; c < 2; c++) begin
      // control/status write
      if (wr_csr[c] && bus_req.be[0]) begin
        csr_w = bus_req.wdata;
        st_d.ch[c].ie = csr_w[`IMT_CSR_IE]; // R8
        st_d.ch[c].cks = csr_w[`IMT_CSR_CKS_HI:`IMT_CSR_CKS_LO]; // R2
        if (!csr_w[`IMT_CSR_FLAG]) begin
          st_d.ch[c].flag = 1'b0; // R7
        end
      end
      // compare constant write
      if (wr_cor[c]) begin
        st_d.ch[c].cor = merge(st_q.ch[c].cor, bus_req.wdata, bus_req.be); // R14
      end
      // counter: match clear > write > increment
      if (match[c]) begin
        st_d.ch[c].cnt = `IMT_RST_CNT; // R12 R16
        st_d.ch[c].flag = 1'b1; // R6 R12
        ev[c] = 1'b1;
      end else if (wr_cnt[c]) begin
        st_d.ch[c].cnt = merge(st_q.ch[c].cnt, bus_req.wdata, bus_req.be); // R17
      end else if (tick[c]) begin
        st_d.ch[c].cnt = st_q.ch[c].cnt + 16'h0001; // R11
      end
    end

    // interrupt status: set wins over clear
    if (bus_req.wr && bus_req.addr == `IMT_OFS_ICLR && bus_req.be[0]) begin
      st_d.ist = st_q.ist & ~bus_req.wdata[1:0];
    end
    st_d.ist = st_d.ist | ev;
    if (bus_req.wr && bus_req.addr == `IMT_OFS_IEN && bus_req.be[0]) begin
      st_d.ien = bus_req.wdata[1:0];
    end

    // standby entry returns run and the channel registers to their reset values; prescaler, status and enables keep theirs
    if (standby) begin
      st_d.run = `IMT_RST_RUN; // R5
      for (int c = 0; c < 2; c++) begin
        st_d.ch[c].flag = 1'b0; // R10
        st_d.ch[c].ie = 1'b0; // R10
        st_d.ch[c].cks = `IMT_RST_CKS; // R10
        st_d.ch[c].cnt = `IMT_RST_CNT; // R13
        st_d.ch[c].cor = `IMT_RST_COR; // R14
      end
    end

    // read data, valid the cycle after the strobe
    st_d.rdata = 16'h0000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `IMT_OFS_RUN: st_d.rdata = {14'h0000, st_q.run}; // R4
        `IMT_OFS_IST: st_d.rdata = {14'h0000, st_q.ist};
        `IMT_OFS_IEN: st_d.rdata = {14'h0000, st_q.ien};
        default: begin
          for (int c = 0; c < 2; c++) begin
            if (bus_req.addr == 8'(`IMT_OFS_CSR0 + c * `IMT_CH_STRIDE)) begin
              st_d.rdata = {8'h00, st_q.ch[c].flag, st_q.ch[c].ie, 4'h0,
                            st_q.ch[c].cks}; // R6 R9
            end
            if (bus_req.addr == 8'(`IMT_OFS_CNT0 + c * `IMT_CH_STRIDE)) begin
              st_d.rdata = st_q.ch[c].cnt;
            end
            if (bus_req.addr == 8'(`IMT_OFS_COR0 + c * `IMT_CH_STRIDE)) begin
              st_d.rdata = st_q.ch[c].cor;
            end
          end
        end
      endcase
    end

    // request lines follow the next flag and enable, irq the next status and enable
    for (int c = 0; c < 2; c++) begin
      st_d.mir[c] = st_d.ch[c].flag && st_d.ch[c].ie; // R1 R8
    end
    st_d.irq = |(st_d.ist & st_d.ien);
  end

  // ==========================================
  // registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q.run <= `IMT_RST_RUN; // R5
      for (int c = 0; c < 2; c++) begin
        st_q.ch[c].flag <= 1'b0; // R10
        st_q.ch[c].ie <= 1'b0;
        st_q.ch[c].cks <= `IMT_RST_CKS;
        st_q.ch[c].cnt <= `IMT_RST_CNT; // R13
        st_q.ch[c].cor <= `IMT_RST_COR; // R14
      end
      st_q.pre <= '0;
      st_q.ist <= 2'h0;
      st_q.ien <= 2'h0;
      st_q.rdata <= 16'h0000;
      st_q.irq <= 1'b0;
      st_q.mir <= 2'h0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign irq = st_q.irq;
  assign match_irq = st_q.mir;

  // ==========================================
  // assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  property p_run_rsv;
    bus_req.rd && bus_req.addr == `IMT_OFS_RUN |=> rdata[15:2] == 14'h0000;
  endproperty
  a_run_rsv: assert property (p_run_rsv) else $error("run reserved bits not zero"); // R4

  property p_csr_rsv;
    bus_req.rd && bus_req.addr == `IMT_OFS_CSR0
      |=> rdata[15:8] == 8'h00 && rdata[5:2] == 4'h0 && rdata[7] == $past(st_q.ch[0].flag);
  endproperty
  a_csr_rsv: assert property (p_csr_rsv) else $error("csr readback wrong"); // R9

  property p_match;
    !standby && match[0] |=> st_q.ch[0].cnt == 16'h0000 && st_q.ch[0].flag;
  endproperty
  a_match: assert property (p_match) else $error("match did not clear and flag"); // R12

  property p_hold;
    !st_q.run[0] && !wr_cnt[0] && !standby |=> $stable(st_q.ch[0].cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped counter moved"); // R11

  property p_tick_only;
    !$past(wr_cnt[0]) && !$past(standby) && st_q.ch[0].cnt != 16'h0000
      && $changed(st_q.ch[0].cnt) |-> $past(tick[0]);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("count without enable"); // R19

  property p_div8;
    st_q.run[0] && st_q.ch[0].cks == 2'h0 && tick[0]
      |=> (!tick[0]) [*7] ##1 (tick[0] || !st_q.run[0] || st_q.ch[0].cks != 2'h0);
  endproperty
  a_div8: assert property (p_div8) else $error("divide-by-8 spacing wrong"); // R2

  property p_w1;
    wr_csr[0] && bus_req.be[0] && bus_req.wdata[7] && !st_q.ch[0].flag && !match[0]
      |=> !st_q.ch[0].flag;
  endproperty
  a_w1: assert property (p_w1) else $error("writing 1 set the flag"); // R7

  property p_mir;
    match_irq[0] == (st_q.ch[0].flag && st_q.ch[0].ie);
  endproperty
  a_mir: assert property (p_mir) else $error("request not flag and enable"); // R8

  property p_standby;
    standby |=> st_q.run == 2'h0 && st_q.ch[1].cnt == 16'h0000
      && st_q.ch[1].cor == 16'hFFFF && !st_q.ch[1].flag;
  endproperty
  a_standby: assert property (p_standby) else $error("standby did not reset"); // R5

  property p_clr_wins;
    !standby && match[1] && wr_cnt[1] |=> st_q.ch[1].cnt == 16'h0000;
  endproperty
  a_clr_wins: assert property (p_clr_wins) else $error("write beat match clear"); // R16

  property p_wr_wins;
    !standby && wr_cnt[1] && !match[1] && bus_req.be == 2'h1
      |=> st_q.ch[1].cnt == {$past(st_q.ch[1].cnt[15:8]), $past(bus_req.wdata[7:0])};
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("byte write lost"); // R17

  property p_run_wr;
    bus_req.wr && bus_req.addr == `IMT_OFS_RUN && bus_req.be[0] && !standby
      |=> st_q.run == $past(bus_req.wdata[1:0]);
  endproperty
  a_run_wr: assert property (p_run_wr) else $error("run bits not written"); // R3

  property p_run_rd;
    bus_req.rd && bus_req.addr == `IMT_OFS_RUN |=> rdata[1:0] == $past(st_q.run);
  endproperty
  a_run_rd: assert property (p_run_rd) else $error("run bits read back wrong"); // R3

  property p_tick_pulse;
    tick[1] |=> !tick[1];
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("count enable too long"); // R19

  property p_hold1;
    !st_q.run[1] && !wr_cnt[1] && !standby |=> $stable(st_q.ch[1].cnt);
  endproperty
  a_hold1: assert property (p_hold1) else $error("stopped counter one moved"); // R11

  property p_inc0;
    !standby && tick[0] && !match[0] && !wr_cnt[0]
      |=> st_q.ch[0].cnt == $past(st_q.ch[0].cnt) + 16'h0001;
  endproperty
  a_inc0: assert property (p_inc0) else $error("counter zero did not advance"); // R11

  property p_inc1;
    !standby && tick[1] && !match[1] && !wr_cnt[1]
      |=> st_q.ch[1].cnt == $past(st_q.ch[1].cnt) + 16'h0001;
  endproperty
  a_inc1: assert property (p_inc1) else $error("counter one did not advance"); // R11

  property p_match1;
    !standby && match[1] |=> st_q.ch[1].cnt == 16'h0000 && st_q.ch[1].flag;
  endproperty
  a_match1: assert property (p_match1) else $error("match one did not clear and flag"); // R12

  property p_flag_src0;
    !standby && !st_q.ch[0].flag && !match[0] |=> !st_q.ch[0].flag;
  endproperty
  a_flag_src0: assert property (p_flag_src0) else $error("flag zero set without match"); // R6

  property p_flag_src1;
    !standby && !st_q.ch[1].flag && !match[1] |=> !st_q.ch[1].flag;
  endproperty
  a_flag_src1: assert property (p_flag_src1) else $error("flag one set without match"); // R6

  property p_ist;
    match[0] |=> st_q.ist[0];
  endproperty
  a_ist: assert property (p_ist) else $error("match did not latch status"); // R1

  property p_cor_wr;
    !standby && wr_cor[0] && bus_req.be == 2'h3 |=> st_q.ch[0].cor == $past(bus_req.wdata);
  endproperty
  a_cor_wr: assert property (p_cor_wr) else $error("constant write lost"); // R14

  property p_rst_vals;
    $rose(rstn) |-> st_q.run == 2'h0 && st_q.ch[0].cnt == 16'h0000
      && st_q.ch[1].cnt == 16'h0000 && st_q.ch[0].cor == 16'hFFFF
      && st_q.ch[1].cor == 16'hFFFF;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong"); // R13

  property p_standby0;
    standby |=> st_q.ch[0].cnt == 16'h0000 && !st_q.ch[0].flag && !st_q.ch[0].ie
      && st_q.ch[0].cks == 2'h0 && st_q.ch[0].cor == 16'hFFFF;
  endproperty
  a_standby0: assert property (p_standby0) else $error("standby left channel zero set"); // R10

  property p_unmapped;
    bus_req.rd && !(|rd_hit) && bus_req.addr != `IMT_OFS_RUN
      && bus_req.addr != `IMT_OFS_IST && bus_req.addr != `IMT_OFS_IEN
      |=> rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // R9

  property p_wr0;
    !standby && wr_csr[0] && bus_req.be[0] && !bus_req.wdata[7] && !match[0]
      |=> !st_q.ch[0].flag;
  endproperty
  a_wr0: assert property (p_wr0) else $error("writing 0 kept the flag"); // R7

  property p_mir1;
    match_irq[1] == (st_q.ch[1].flag && st_q.ch[1].ie);
  endproperty
  a_mir1: assert property (p_mir1) else $error("request one not flag and enable"); // R8

  property p_wr_full;
    !standby && wr_cnt[0] && !match[0] && bus_req.be == 2'h3
      |=> st_q.ch[0].cnt == $past(bus_req.wdata);
  endproperty
  a_wr_full: assert property (p_wr_full) else $error("word write lost"); // R17

  property p_csr1_rsv;
    bus_req.rd && rd_hit[1] && bus_req.addr[3:0] == 4'h4
      |=> rdata[15:8] == 8'h00 && rdata[5:2] == 4'h0 && rdata[7] == $past(st_q.ch[1].flag);
  endproperty
  a_csr1_rsv: assert property (p_csr1_rsv) else $error("csr one readback wrong"); // R9

  c_match0: cover property (match[0] && st_q.ch[0].ie);
  c_match1: cover property (match[1]);
  c_irq: cover property (irq);
  c_clash: cover property (match[0] && wr_cnt[0]);
  c_clash1: cover property (match[1] && wr_cnt[1]);

endmodule

// ---- rtl/imt_consts.svh ----
// constants of the interval match timer: offsets, fields, reset values
// assumes byte addresses on an 8-bit register port, one 16-bit register a word
`ifndef IMT_CONSTS_SVH
`define IMT_CONSTS_SVH

// ==========================================
// register offsets
`define IMT_OFS_RUN 8'h00
`define IMT_OFS_CSR0 8'h04
`define IMT_OFS_CNT0 8'h08
`define IMT_OFS_COR0 8'h0C
`define IMT_CH_STRIDE 8'h10
`define IMT_OFS_IST 8'h20
`define IMT_OFS_ICLR 8'h24
`define IMT_OFS_IEN 8'h28

// ==========================================
// field positions
`define IMT_CSR_FLAG 7
`define IMT_CSR_IE 6
`define IMT_CSR_CKS_HI 1
`define IMT_CSR_CKS_LO 0

// ==========================================
// reset values
`define IMT_RST_RUN 2'h0
`define IMT_RST_CNT 16'h0000
`define IMT_RST_COR 16'hFFFF
`define IMT_RST_CKS 2'h0

// ==========================================
// prescaler: divide by 8, 32, 128, 512
`define IMT_PRE_W 9
`define IMT_DIV8_BITS 3
`define IMT_DIV_STEP 2

`endif

// ---- rtl/imt_pkg.sv ----
// types of the interval match timer
// assumes imt_consts.svh is on the include path
`include "imt_consts.svh"

package imt_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic wr;
    logic rd;
  } imt_bus_req_t;

  typedef struct packed {
    logic flag;
    logic ie;
    logic [1:0] cks;
    logic [15:0] cnt;
    logic [15:0] cor;
  } imt_chan_t;

  typedef struct packed {
    logic [1:0] run;
    imt_chan_t [1:0] ch;
    logic [`IMT_PRE_W-1:0] pre;
    logic [1:0] ist;
    logic [1:0] ien;
    logic [15:0] rdata;
    logic irq;
    logic [1:0] mir;
  } imt_state_t;

endpackage

// ---- tb/imt_intc_model.sv ----
// interrupt controller stand-in: counts rises of the request lines
// assumes request levels synchronous to core_clk
module imt_intc_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic irq,
  input wire logic [1:0] match_irq,
  output int n_rise,
  output int n_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] last_q;
  // ==========
  // edge counting
  always @(posedge core_clk) begin
    if (!rstn) begin
      n_rise <= 0;
      n_irq <= 0;
    end else begin
      n_rise <= n_rise + int'(match_irq[0] && !last_q[0])
        + int'(match_irq[1] && !last_q[1]);
      if (irq && !last_q[2]) n_irq <= n_irq + 1;
    end
    last_q <= {irq, match_irq};
  end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench of the interval match timer with a register model
// assumes imt_pkg, imt_timer and imt_intc_model are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic standby = 1'b0;
  imt_pkg::imt_bus_req_t req = '0;
  logic [15:0] rdata;
  logic irq;
  logic [1:0] match_irq;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_rise, n_irq, t0, cor;
  int mdl[int];
  logic [15:0] v;
  logic [7:0] b;
  imt_timer DUT (.core_clk(core_clk), .rstn(rstn), .standby(standby), .bus_req(req),
    .rdata(rdata), .irq(irq), .match_irq(match_irq));
  imt_intc_model intc (.core_clk(core_clk), .rstn(rstn), .irq(irq),
    .match_irq(match_irq), .n_rise(n_rise), .n_irq(n_irq));
  always #2 core_clk = ~core_clk;
  // ==========
  // reporting
  task automatic complete_run();
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ==========
  // register model and bus master
  function automatic int mdl_wr(input logic [7:0] a, input int old, input logic [15:0] d,
    input logic [1:0] be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    if (a == 8'h00 || a == 8'h28) return be[0] ? int'(d & 16'h0003) : old;
    if (a[3:0] == 4'h4) return be[0] ? int'((d & 16'h0043) | (old & d & 16'h0080)) : old;
    return int'((old & ~m) | (d & m));
  endfunction
  task automatic mdl_rst(input bit all);
    mdl[8'h00] = 0;
    for (int c = 0; c < 32; c += 16) begin
      mdl[c + 4] = 0;
      mdl[c + 8] = 0;
      mdl[c + 12] = 16'hFFFF;
    end
    if (all) mdl[8'h28] = 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
    if (mdl.exists(a)) mdl[a] = mdl_wr(a, mdl[a], d, be);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    rd(a, v);
    check($sformatf("reg %h", a), v, 16'(mdl[a]));
  endtask
  task automatic clear_flag(input logic [7:0] a);
    rd(a + 8'h04, v);
    wr(a + 8'h04, v & 16'hFF7F, 2'h3);
  endtask
  task automatic wait_match(input int ch);
    int n;
    n = 0;
    while (match_irq[ch] !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("match seen", 16'(n < 4000), 16'h0001);
    mdl[16 * ch + 4] = mdl[16 * ch + 4] | 16'h0080;
  endtask
  // ==========
  // scenarios
  initial begin
    void'($urandom(91));
    mdl_rst(1'b1);
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (mdl[a]) rd_chk(8'(a));
    wr(8'h00, 16'hFFFC, 2'h3);
    wr(8'h04, 16'hFFBC, 2'h3);
    wr(8'h30, 16'hFFFF, 2'h3);
    rd(8'h30, v);
    check("unmapped", v, 16'h0000);
    foreach (mdl[a]) rd_chk(8'(a));
    wr(8'h28, 16'h0003, 2'h3);
    for (int ks = 0; ks < 4; ks++) begin
      b = 8'(16 * (ks % 2));
      cor = $urandom_range(4, 1);
      wr(b + 8'h08, 16'h0000, 2'h3);
      wr(b + 8'h0C, 16'(cor), 2'h3);
      wr(b + 8'h04, 16'(64 + ks), 2'h3);
      wr(8'h00, 16'(1 << (ks % 2)), 2'h3);
      wait_match(ks % 2);
      t0 = cyc;
      clear_flag(b);
      wait_match(ks % 2);
      t0 = cyc - t0;
      wr(8'h00, 16'h0000, 2'h3);
      check("period", 16'(t0), 16'((cor + 1) * (8 << (2 * ks))));
      check("irq lines", 16'({irq, match_irq}), 16'(4 + (1 << (ks % 2))));
      rd_chk(b + 8'h04);
      clear_flag(b);
      check("flag clear", 16'(match_irq), 16'h0000);
    end
    check("rises", 16'(n_rise), 16'h0008);
    rd(8'h20, v);
    check("status", v, 16'h0003);
    wr(8'h28, 16'h0000, 2'h3);
    check("masked", 16'(irq), 16'h0000);
    wr(8'h28, 16'h0003, 2'h3);
    wr(8'h24, 16'h0003, 2'h3);
    rd(8'h20, v);
    check("cleared", {v[14:0], irq}, 16'h0000);
    check("irq rises", 16'(n_irq), 16'h0002);
    wr(8'h14, 16'h0000, 2'h3);
    wr(8'h1C, 16'h0005, 2'h3);
    wr(8'h00, 16'h0002, 2'h3);
    @(posedge core_clk);
    req <= '{addr: 8'h18, wdata: 16'h0005, be: 2'h3, wr: 1'b1, rd: 1'b0};
    repeat (9) @(posedge core_clk);
    req.wr <= 1'b0;
    wr(8'h00, 16'h0000, 2'h3);
    mdl[8'h14] = 16'h0080;
    rd_chk(8'h14);
    rd(8'h20, v);
    check("clash status", v, 16'h0002);
    wr(8'h18, 16'h1234, 2'h3);
    repeat (600) @(posedge core_clk);
    rd_chk(8'h18);
    wr(8'h18, 16'hABCD, 2'h1);
    rd_chk(8'h18);
    wr(8'h00, 16'h0003, 2'h3);
    @(posedge core_clk);
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    mdl_rst(1'b0);
    foreach (mdl[a]) rd_chk(8'(a));
    complete_run();
  end
endmodule
